// >>> rtl/pxg_port_crossbar.sv
`timescale 1ns/10ps
// Contract
// R1: Pullup-disable 0 enables weak pullups except analog pins; 1 disables all.
// R2: Crossbar enable bit turns peripheral routing to pins on and off.
// R3: Timer 1 input routing bit gives timer 1 input a pin, else none.
// R4: Timer 0 input routing bit gives timer 0 input a pin, else none.
// R5: Count input routing bit gives counter-array count input a pin, else none.
// R6: Compare field routes modules 0..N-1 for codes 1..6; 0 and 7 route none.
// R7: Port latches reachable as whole bytes and as single bits.
// R8: Port writes stored in the latch, held until written again.
// R9: Ordinary port read returns pin levels whatever the crossbar assignment.
// R10: Read-modify-write accesses read the latch, not the pins.
// R11: Match event when masked pins differ from masked match value, either port.
// R12: Match event requests interrupt when enabled and can wake the oscillator.
// R13: Latch 0 drives low; 1 drives high or floats when open-drain.
// R14: Analog pins read 0; digital pins read the pin level.
// R15: Input-mode 0 makes pin analog: no pullup, driver or receiver.
// R16: Output-mode 0 open-drain, 1 push-pull; ignored for analog pins.
// R17: Two-wire data and clock pins always open-drain.
// R18: Skip bit 1 makes the crossbar pass over that pin.
// R19: Mask bit 0 removes the pin from the match comparison.
// R20: Overdrive select bit per pin: 0 normal, 1 high-impedance; reset 0. Only port 0 pins have one here.
// R21: Software writes latch 1 on pins it puts in analog mode.
// R22: Crossbar disabled keeps all pins inputs with drivers off.
// R23: Each selected peripheral gets the lowest free, unskipped pin in priority.
// R24: Pullup off on pins driving low; pullups only on open-drain pins. Push-pull pins here also get one while the crossbar is disabled.
// R25: Pin levels pass a two-stage synchroniser before reads and matching.
module pxg_port_crossbar (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Byte access on the register bus
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic [7:0]  sfrWrData,
    input  wire logic        sfrRdEn,
    input  wire logic        sfrRmw,
    output logic      [7:0]  sfrRdData,
    // Bit access on the register bus
    input  wire logic [7:0]  bitAddr,
    input  wire logic        bitWrEn,
    input  wire logic        bitWrData,
    input  wire logic        bitRdEn,
    input  wire logic        bitRmw,
    output logic             bitRdData,
    // Pins: port 0 in bits 7:0, port 1 in bits 15:8; overdrive select covers port 0 only
    input  wire logic [15:0] pinIn,
    output logic      [15:0] pinOut,
    output logic      [15:0] pinOeN,
    output logic      [15:0] pinPullupEn,
    output logic      [7:0]  pinOverdriveHiZ,
    // Peripherals routed through the crossbar
    input  wire logic        smbRouteEn,
    input  wire logic        smbDataOut,
    input  wire logic        smbClkOut,
    input  wire logic [5:0]  cexOut,
    output logic             smbDataIn,
    output logic             smbClkIn,
    output logic             counterCountIn,
    output logic             timer0In,
    output logic             timer1In,
    // Port match
    input  wire logic        portMatchIrqEnable,
    output logic             portMatchEvent,
    output logic             portMatchIrq,
    output logic             oscWakeReq
);

    // Configuration and latch registers
    logic [7:0] p0Latch_reg;
    logic [7:0] p1Latch_reg;
    logic [7:0] p0OutMode_reg;
    logic [7:0] p0Overdrive_reg;
    logic [7:0] port0_match_mask_reg;
    logic [7:0] p0Match_reg;
    logic [7:0] port1_match_mask_reg;
    logic [7:0] port1_match_value_reg;
    logic [7:0] port0_skip_select_reg;
    logic [7:0] xbarCtl_reg;
    logic [7:0] p0InMode_reg;
    logic [7:0] p0Latch_next;
    logic [7:0] p1Latch_next;

    // Synchronised pins and derived read values
    logic [15:0] pinSync;
    logic [15:0] pinRead;
    logic [15:0] latchAll;
    logic [15:0] digitalAll;
    logic [15:0] pushPullAll;
    logic [15:0] skipAll;

    pxg_sync2 #(
        .WIDTH   (pxg_pkg::PIN_COUNT)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    ); // R25

    // Port 1 configuration lives outside this block: digital, open-drain, unskipped
    assign latchAll    = {p1Latch_reg, p0Latch_reg};
    assign digitalAll  = {8'hff, p0InMode_reg};
    assign pushPullAll = {8'h00, p0OutMode_reg};
    assign skipAll     = {8'h00, port0_skip_select_reg};
    assign pinRead     = pinSync & digitalAll; // R14 R15

    // Crossbar control fields
    logic       pullupDis;
    logic       xbarEn;
    logic       t1Route;
    logic       t0Route;
    logic       cntRoute;
    logic [2:0] cexCode;
    logic [4:0] smbN;
    logic [4:0] cexEnd;
    logic [4:0] cntPos;
    logic [4:0] t0Pos;
    logic [4:0] t1Pos;

    assign pullupDis = xbarCtl_reg[pxg_pkg::XBC_PULLUP_DIS];
    assign xbarEn    = xbarCtl_reg[pxg_pkg::XBC_XBAR_EN];
    assign t1Route   = xbarCtl_reg[pxg_pkg::XBC_T1_ROUTE];
    assign t0Route   = xbarCtl_reg[pxg_pkg::XBC_T0_ROUTE];
    assign cntRoute  = xbarCtl_reg[pxg_pkg::XBC_CNT_ROUTE];
    assign cexCode   = xbarCtl_reg[pxg_pkg::XBC_CEX_MSB:pxg_pkg::XBC_CEX_LSB];

    // Priority slots: two-wire pair, compare outputs, count input, timer 0, timer 1
    assign smbN   = smbRouteEn ? pxg_pkg::SMB_PIN_COUNT : 5'h00;
    assign cexEnd = 5'(smbN + ((cexCode <= pxg_pkg::CEX_CODE_MAX) ? {2'h0, cexCode} : 5'h00)); // R6
    assign cntPos = cexEnd;
    assign t0Pos  = 5'(cntPos + {4'h0, cntRoute});
    assign t1Pos  = 5'(t0Pos + {4'h0, t0Route});

    // Pin assignment by rank among unskipped pins
    pxg_pkg::pxg_sel_t pinSel [pxg_pkg::PIN_COUNT];
    logic [2:0]        pinCex [pxg_pkg::PIN_COUNT];

    // Rank counts only unskipped pins, so a skipped pin never consumes a slot
    always_comb begin
        logic [4:0] rank;
        rank = 5'h00;
        for (int i = 0; i < pxg_pkg::PIN_COUNT; i++) begin
            pinSel[i] = pxg_pkg::SEL_GPIO;
            pinCex[i] = 3'h0;
            if (xbarEn && !skipAll[i]) begin // R2 R18
                if (rank < smbN) begin
                    pinSel[i] = (rank == 5'h00) ? pxg_pkg::SEL_SDA : pxg_pkg::SEL_SCL;
                end else if (rank < cexEnd) begin // R6
                    pinSel[i] = pxg_pkg::SEL_CEX;
                    pinCex[i] = 3'(rank - smbN);
                end else if (cntRoute && rank == cntPos) begin // R5
                    pinSel[i] = pxg_pkg::SEL_CNT;
                end else if (t0Route && rank == t0Pos) begin // R4
                    pinSel[i] = pxg_pkg::SEL_T0;
                end else if (t1Route && rank == t1Pos) begin // R3
                    pinSel[i] = pxg_pkg::SEL_T1;
                end
                rank = 5'(rank + 5'h01); // R23
            end
        end
    end

    // Pin drive, enable and pullup for the next cycle
    logic [15:0] pinOut_next;
    logic [15:0] pinOeN_next;
    logic [15:0] pullup_next;

    always_comb begin
        logic val;
        logic isSmb;
        logic drive;
        val   = 1'b1;
        isSmb = 1'b0;
        drive = 1'b0;
        for (int i = 0; i < pxg_pkg::PIN_COUNT; i++) begin
            isSmb = (pinSel[i] == pxg_pkg::SEL_SDA) || (pinSel[i] == pxg_pkg::SEL_SCL);
            case (pinSel[i])
                pxg_pkg::SEL_SDA: val = smbDataOut;
                pxg_pkg::SEL_SCL: val = smbClkOut;
                pxg_pkg::SEL_CEX: val = cexOut[pinCex[i]];
                default:          val = latchAll[i]; // R8
            endcase
            // Low driven on digital pins while the crossbar is enabled; high only when push-pull and not a two-wire pin
            drive = xbarEn && digitalAll[i]
                    && (!val || (pushPullAll[i] && !isSmb)); // R13 R16 R17 R22 R15
            pinOut_next[i] = val;
            pinOeN_next[i] = !drive;
            // Released open-drain and undriven inputs get the pullup; driven pins never
            pullup_next[i] = !pullupDis && digitalAll[i] && !drive; // R1 R24
        end
    end

    // Peripheral inputs taken from their assigned pins
    logic sda_next;
    logic scl_next;
    logic cnt_next;
    logic t0_next;
    logic t1_next;

    // Unrouted inputs read 0, except the two-wire pair which idles high
    always_comb begin
        sda_next = 1'b1;
        scl_next = 1'b1;
        cnt_next = 1'b0;
        t0_next  = 1'b0;
        t1_next  = 1'b0;
        for (int i = 0; i < pxg_pkg::PIN_COUNT; i++) begin
            case (pinSel[i])
                pxg_pkg::SEL_SDA: sda_next = pinRead[i];
                pxg_pkg::SEL_SCL: scl_next = pinRead[i];
                pxg_pkg::SEL_CNT: cnt_next = pinRead[i]; // R5
                pxg_pkg::SEL_T0:  t0_next  = pinRead[i]; // R4
                pxg_pkg::SEL_T1:  t1_next  = pinRead[i]; // R3
                default:          ;
            endcase
        end
    end

    // Write strobes and bit-read selects
    logic wrP0;
    logic wrP1;
    logic bitWrP0;
    logic bitWrP1;
    logic bitRdP0;
    logic bitRdP1;
    logic [2:0] bitIdx;

    assign wrP0    = sfrWrEn && sfrAddr == pxg_pkg::ADDR_P0_LATCH;
    assign wrP1    = sfrWrEn && sfrAddr == pxg_pkg::ADDR_P1_LATCH;
    assign bitIdx  = bitAddr[2:0];
    assign bitWrP0 = bitWrEn && bitAddr[7:3] == pxg_pkg::BIT_BLOCK_P0;
    assign bitWrP1 = bitWrEn && bitAddr[7:3] == pxg_pkg::BIT_BLOCK_P1;
    assign bitRdP0 = bitAddr[7:3] == pxg_pkg::BIT_BLOCK_P0;
    assign bitRdP1 = bitAddr[7:3] == pxg_pkg::BIT_BLOCK_P1;

    // Byte write wins over a bit write to the same latch in the same cycle
    always_comb begin
        p0Latch_next = p0Latch_reg;
        p1Latch_next = p1Latch_reg;
        if (bitWrP0) p0Latch_next[bitIdx] = bitWrData; // R7
        if (bitWrP1) p1Latch_next[bitIdx] = bitWrData; // R7
        if (wrP0) p0Latch_next = sfrWrData; // R8
        if (wrP1) p1Latch_next = sfrWrData; // R8
    end

    // Byte read select: latch for read-modify-write, pins otherwise
    logic [7:0] rdSel;
    logic       bitRdSel;

    assign rdSel =
        (sfrAddr == pxg_pkg::ADDR_P0_LATCH)     ? (sfrRmw ? p0Latch_reg : pinRead[7:0]) :
        (sfrAddr == pxg_pkg::ADDR_P1_LATCH)     ? (sfrRmw ? p1Latch_reg : pinRead[15:8]) :
        (sfrAddr == pxg_pkg::ADDR_P0_OUT_MODE)  ? p0OutMode_reg :
        (sfrAddr == pxg_pkg::ADDR_P0_OVERDRIVE) ? p0Overdrive_reg :
        (sfrAddr == pxg_pkg::ADDR_P1_MASK)      ? port1_match_mask_reg :
        (sfrAddr == pxg_pkg::ADDR_P0_MASK)      ? port0_match_mask_reg :
        (sfrAddr == pxg_pkg::ADDR_P1_MATCH)     ? port1_match_value_reg :
        (sfrAddr == pxg_pkg::ADDR_P0_SKIP)      ? port0_skip_select_reg :
        (sfrAddr == pxg_pkg::ADDR_P0_MATCH)     ? p0Match_reg :
        (sfrAddr == pxg_pkg::ADDR_XBAR_CTL)     ? xbarCtl_reg :
        (sfrAddr == pxg_pkg::ADDR_P0_IN_MODE)   ? p0InMode_reg :
        pxg_pkg::READ_UNMAPPED; // R9 R10
    assign bitRdSel =
        bitRdP0 ? (bitRmw ? p0Latch_reg[bitIdx] : pinRead[bitIdx]) :
        bitRdP1 ? (bitRmw ? p1Latch_reg[bitIdx] : pinRead[{1'b1, bitIdx}]) :
        1'b0; // R9 R10

    // Masked comparison of both ports; a level, live while the mismatch lasts
    logic matchNow;
    assign matchNow = ((pinRead[7:0] & port0_match_mask_reg) != (p0Match_reg & port0_match_mask_reg))
                   || ((pinRead[15:8] & port1_match_mask_reg) != (port1_match_value_reg & port1_match_mask_reg)); // R11 R19

    // Latches and configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            p0Latch_reg <= pxg_pkg::RST_LATCH;
            p1Latch_reg <= pxg_pkg::RST_LATCH;
        end else begin
            p0Latch_reg <= p0Latch_next;
            p1Latch_reg <= p1Latch_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            p0OutMode_reg   <= pxg_pkg::RST_OUT_MODE;
            p0Overdrive_reg <= pxg_pkg::RST_OVERDRIVE; // R20
            port0_match_mask_reg      <= pxg_pkg::RST_MASK;
            p0Match_reg     <= pxg_pkg::RST_MATCH;
            port1_match_mask_reg      <= pxg_pkg::RST_MASK;
            port1_match_value_reg     <= pxg_pkg::RST_MATCH;
            port0_skip_select_reg      <= pxg_pkg::RST_SKIP;
            xbarCtl_reg     <= pxg_pkg::RST_XBAR_CTL;
            p0InMode_reg    <= pxg_pkg::RST_IN_MODE; // R15
        end else if (sfrWrEn) begin
            case (sfrAddr)
                pxg_pkg::ADDR_P0_OUT_MODE:  p0OutMode_reg   <= sfrWrData; // R16
                pxg_pkg::ADDR_P0_OVERDRIVE: p0Overdrive_reg <= sfrWrData; // R20
                pxg_pkg::ADDR_P0_MASK:      port0_match_mask_reg      <= sfrWrData;
                pxg_pkg::ADDR_P0_MATCH:     p0Match_reg     <= sfrWrData;
                pxg_pkg::ADDR_P1_MASK:      port1_match_mask_reg      <= sfrWrData;
                pxg_pkg::ADDR_P1_MATCH:     port1_match_value_reg     <= sfrWrData;
                pxg_pkg::ADDR_P0_SKIP:      port0_skip_select_reg      <= sfrWrData; // R18
                pxg_pkg::ADDR_XBAR_CTL:     xbarCtl_reg     <= sfrWrData;
                pxg_pkg::ADDR_P0_IN_MODE:   p0InMode_reg    <= sfrWrData;
                default:                    ;
            endcase
        end
    end

    // Read data are registered: answer one edge after the strobe, held until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sfrRdData <= pxg_pkg::READ_UNMAPPED;
            bitRdData <= 1'b0;
        end else begin
            if (sfrRdEn) sfrRdData <= rdSel;
            if (bitRdEn) bitRdData <= bitRdSel;
        end
    end

    // Pin and peripheral outputs; reset leaves every pin an undriven input
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinOut          <= 16'hffff;
            pinOeN          <= 16'hffff;
            pinPullupEn     <= 16'h0000;
            pinOverdriveHiZ <= pxg_pkg::RST_OVERDRIVE;
            smbDataIn       <= 1'b1;
            smbClkIn        <= 1'b1;
            counterCountIn  <= 1'b0;
            timer0In        <= 1'b0;
            timer1In        <= 1'b0;
        end else begin
            pinOut          <= pinOut_next;
            pinOeN          <= pinOeN_next;
            pinPullupEn     <= pullup_next;
            pinOverdriveHiZ <= p0Overdrive_reg; // R20
            smbDataIn       <= sda_next;
            smbClkIn        <= scl_next;
            counterCountIn  <= cnt_next;
            timer0In        <= t0_next;
            timer1In        <= t1_next;
        end
    end

    // Match event, gated interrupt request and oscillator wake
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            portMatchEvent <= 1'b0;
            portMatchIrq   <= 1'b0;
            oscWakeReq     <= 1'b0;
        end else begin
            portMatchEvent <= matchNow; // R11
            portMatchIrq   <= matchNow && portMatchIrqEnable; // R12
            oscWakeReq     <= matchNow; // R12
        end
    end

    // Checks
    AST_PULLUP_DISABLED: assert property ( // R1
        @(posedge sys_clk) disable iff (rst)
        pullupDis |=> (pinPullupEn == 16'h0000))
        else $error("pullup active while pullups disabled");

    AST_XBAR_OFF_NO_DRIVE: assert property ( // R22
        @(posedge sys_clk) disable iff (rst)
        !xbarEn |=> (pinOeN == 16'hffff))
        else $error("pin driven while crossbar disabled");

    AST_ANALOG_READS_ZERO: assert property ( // R14
        @(posedge sys_clk) disable iff (rst)
        (sfrRdEn && sfrAddr == pxg_pkg::ADDR_P0_LATCH && !sfrRmw)
        |=> ((sfrRdData & ~$past(p0InMode_reg)) == 8'h00))
        else $error("analog pin read as nonzero");

    AST_PIN_READ_SYNCED: assert property ( // R9
        @(posedge sys_clk) disable iff (rst)
        (sfrRdEn && sfrAddr == pxg_pkg::ADDR_P0_LATCH && !sfrRmw) ##1 !$past(rst, 3)
        |-> (sfrRdData == ($past(pinIn[7:0], 3) & $past(p0InMode_reg))))
        else $error("port read not the synchronised pin level");

    AST_RMW_READS_LATCH: assert property ( // R10
        @(posedge sys_clk) disable iff (rst)
        (sfrRdEn && sfrAddr == pxg_pkg::ADDR_P1_LATCH && sfrRmw)
        |=> (sfrRdData == $past(p1Latch_reg)))
        else $error("read-modify-write did not read the latch");

    AST_LATCH_HOLDS_WRITE: assert property ( // R8
        @(posedge sys_clk) disable iff (rst)
        (wrP0 ##1 (!sfrWrEn && !bitWrEn)) |=> (p0Latch_reg == $past(sfrWrData, 2)))
        else $error("latch lost written value");

    AST_MASK_ZERO_NO_EVENT: assert property ( // R19
        @(posedge sys_clk) disable iff (rst)
        (port0_match_mask_reg == 8'h00 && port1_match_mask_reg == 8'h00) |=> !portMatchEvent)
        else $error("match event with all pins masked");

    AST_IRQ_NEEDS_EVENT: assert property ( // R12
        @(posedge sys_clk) disable iff (rst)
        portMatchIrq |-> (portMatchEvent && oscWakeReq && $past(portMatchIrqEnable)))
        else $error("interrupt without enabled match event");

    AST_SMB_OPEN_DRAIN: assert property ( // R17
        @(posedge sys_clk) disable iff (rst)
        (pinSel[0] == pxg_pkg::SEL_SDA && smbDataOut) |=> pinOeN[0])
        else $error("two-wire pin driven high");

    AST_LATCH_LOW_DRIVES: assert property ( // R13
        @(posedge sys_clk) disable iff (rst)
        (xbarEn && p0InMode_reg[0] && pinSel[0] == pxg_pkg::SEL_GPIO && !p0Latch_reg[0])
        |=> (!pinOeN[0] && !pinOut[0]))
        else $error("latch 0 did not drive pin low");

    AST_FIRST_PIN_SDA: assert property ( // R23
        @(posedge sys_clk) disable iff (rst)
        (xbarEn && smbRouteEn && !port0_skip_select_reg[0]) |-> (pinSel[0] == pxg_pkg::SEL_SDA))
        else $error("two-wire data not on lowest free pin");

endmodule

// >>> include/pxg_pkg.sv
package pxg_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_P0_LATCH     = 8'h80;
    localparam logic [7:0] ADDR_P1_LATCH     = 8'h90;
    localparam logic [7:0] ADDR_P0_OUT_MODE  = 8'ha4;
    localparam logic [7:0] ADDR_P0_OVERDRIVE = 8'hb0;
    localparam logic [7:0] ADDR_P1_MASK      = 8'hbf;
    localparam logic [7:0] ADDR_P0_MASK      = 8'hc7;
    localparam logic [7:0] ADDR_P1_MATCH     = 8'hcf;
    localparam logic [7:0] ADDR_P0_SKIP      = 8'hd4;
    localparam logic [7:0] ADDR_P0_MATCH     = 8'hd7;
    localparam logic [7:0] ADDR_XBAR_CTL     = 8'he2;
    localparam logic [7:0] ADDR_P0_IN_MODE   = 8'hf1;

    // Bit-address block of each bit-addressable port (bit address bits 7:3)
    localparam logic [4:0] BIT_BLOCK_P0 = 5'h10;
    localparam logic [4:0] BIT_BLOCK_P1 = 5'h12;

    // Reset values
    localparam logic [7:0] RST_LATCH     = 8'hff;
    localparam logic [7:0] RST_OUT_MODE  = 8'h00;
    localparam logic [7:0] RST_OVERDRIVE = 8'h00;
    localparam logic [7:0] RST_MASK      = 8'h00;
    localparam logic [7:0] RST_MATCH     = 8'hff;
    localparam logic [7:0] RST_XBAR_CTL  = 8'h00;
    localparam logic [7:0] RST_IN_MODE   = 8'hff;
    localparam logic [7:0] RST_SKIP      = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Crossbar control field positions
    localparam int XBC_PULLUP_DIS = 7;
    localparam int XBC_XBAR_EN    = 6;
    localparam int XBC_T1_ROUTE   = 5;
    localparam int XBC_T0_ROUTE   = 4;
    localparam int XBC_CNT_ROUTE  = 3;
    localparam int XBC_CEX_MSB    = 2;
    localparam int XBC_CEX_LSB    = 0;
    localparam logic [2:0] CEX_CODE_MAX = 3'h6;

    // Sizes
    localparam int PORT_W    = 8;
    localparam int PIN_COUNT = 16;
    localparam int CEX_COUNT = 6;
    localparam logic [4:0] SMB_PIN_COUNT = 5'h02;

    // Function that the crossbar gives a pin
    typedef enum logic [2:0] {
        SEL_GPIO = 3'h0,
        SEL_SDA  = 3'h1,
        SEL_SCL  = 3'h3,
        SEL_CEX  = 3'h2,
        SEL_CNT  = 3'h6,
        SEL_T0   = 3'h7,
        SEL_T1   = 3'h5
    } pxg_sel_t;

endpackage

// >>> rtl/pxg_sync2.sv
`timescale 1ns/10ps
module pxg_sync2 #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    // Two stages; only the second stage reads the first
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule

// >>> dv/pxg_pin_model.sv
`timescale 1ns/10ps
module pxg_pin_model (
    // Clock
    input  wire logic        sys_clk,
    // Device side of the pads
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOeN,
    input  wire logic [15:0] pinPullupEn,
    // Outside drivers
    input  wire logic [15:0] extEn,
    input  wire logic [15:0] extVal,
    // Resolved pad levels
    output logic      [15:0] pinIn
);
    logic [15:0] lastLvl;

    // Device drive wins; a floating pad toggles so no stale level reads right by luck
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!pinOeN[i])
                pinIn[i] = pinOut[i];
            else if (extEn[i])
                pinIn[i] = extVal[i];
            else
                pinIn[i] = pinPullupEn[i] | ~lastLvl[i];
        end
    end

    // Last resolved level
    always_ff @(posedge sys_clk) begin
        lastLvl <= pinIn;
    end
endmodule

// >>> dv/test_pxg_port_crossbar.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_pxg_port_crossbar;
    logic        sys_clk, rst, sfrWrEn, sfrRdEn, sfrRmw, bitWrEn, bitWrData, bitRdEn, bitRmw;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, bitAddr, pinOverdriveHiZ, v;
    logic [15:0] pinIn, pinOut, pinOeN, pinPullupEn, extEn, extVal;
    logic        smbRouteEn, smbDataOut, smbClkOut, smbDataIn, smbClkIn, bitRdData;
    logic        counterCountIn, timer0In, timer1In, portMatchIrqEnable;
    logic        portMatchEvent, portMatchIrq, oscWakeReq;
    logic [5:0]  cexOut;
    int          errorCnt, testsRun;
    logic [7:0]  addrs[12] = '{8'h80, 8'h90, 8'ha4, 8'hb0, 8'hbf, 8'hc7, 8'hcf, 8'hd4,
                               8'hd7, 8'he2, 8'hf1, 8'h81};
    logic [7:0]  rstv[12]  = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
                               8'hff, 8'h00, 8'hff, 8'h00};

    pxg_port_crossbar u_pxg_port_crossbar (
        .sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw), .sfrRdData(sfrRdData),
        .bitAddr(bitAddr), .bitWrEn(bitWrEn), .bitWrData(bitWrData), .bitRdEn(bitRdEn),
        .bitRmw(bitRmw), .bitRdData(bitRdData), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .pinPullupEn(pinPullupEn), .pinOverdriveHiZ(pinOverdriveHiZ),
        .smbRouteEn(smbRouteEn), .smbDataOut(smbDataOut), .smbClkOut(smbClkOut),
        .cexOut(cexOut), .smbDataIn(smbDataIn), .smbClkIn(smbClkIn),
        .counterCountIn(counterCountIn), .timer0In(timer0In), .timer1In(timer1In),
        .portMatchIrqEnable(portMatchIrqEnable), .portMatchEvent(portMatchEvent),
        .portMatchIrq(portMatchIrq), .oscWakeReq(oscWakeReq));
    pxg_pin_model u_pxg_pin_model (.sys_clk(sys_clk), .pinOut(pinOut), .pinOeN(pinOeN),
        .pinPullupEn(pinPullupEn), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One byte write; an idle edge follows so back-to-back strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a; sfrWrData = d; sfrWrEn = 1'b1;
        tick(1);
        sfrWrEn = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic rmw);
        sfrAddr = a; sfrRmw = rmw; sfrRdEn = 1'b1;
        tick(1);
        sfrRdEn = 1'b0; sfrRmw = 1'b0; v = sfrRdData;
        tick(1);
    endtask

    task automatic stop_test;
        if (errorCnt == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reset values of every register, plus an unmapped address
    task automatic resetState;
        for (int i = 0; i < 12; i++) begin
            rd(addrs[i], 1'b1);
            `CHK("reg", rstv[i], v)
        end
        `CHK("oe", 16'hffff, pinOeN)
        `CHK("pullup", 16'hffff, pinPullupEn)
    endtask

    // Byte and bit access to the latches; modify-reads see the latch
    task automatic latchAccess;
        wr(8'h80, 8'h5a);
        rd(8'h80, 1'b1);
        `CHK("p0 latch", 8'h5a, v)
        bitAddr = 8'h93; bitWrData = 1'b0; bitWrEn = 1'b1;
        tick(1);
        bitWrEn = 1'b0; bitRmw = 1'b1; bitRdEn = 1'b1;
        tick(1);
        bitRdEn = 1'b0;
        `CHK("bit", 1'b0, bitRdData)
        rd(8'h90, 1'b1);
        `CHK("p1 latch", 8'hf7, v)
        wr(8'h80, 8'hff);
        wr(8'h90, 8'hff);
        wr(8'hb0, 8'h81);
        tick(2);
        `CHK("overdrive", 8'h81, pinOverdriveHiZ)
    endtask

    // Plain reads return pads; analog pins read 0
    task automatic pinRead;
        extEn = 16'hffff; extVal = 16'ha5c3;
        tick(3);
        rd(8'h80, 1'b0);
        `CHK("p0 pins", 8'hc3, v)
        rd(8'h90, 1'b0);
        `CHK("p1 pins", 8'ha5, v)
        rd(8'h80, 1'b1);
        `CHK("p0 rmw", 8'hff, v)
        wr(8'hf1, 8'hfe);
        tick(3);
        rd(8'h80, 1'b0);
        `CHK("analog", 8'hc2, v)
        `CHK("analog pullup", 1'b0, pinPullupEn[0])
        wr(8'hf1, 8'hff);
    endtask

    task automatic waitEvent;
        for (int i = 0; i < 8 && portMatchEvent !== 1'b1; i++)
            tick(1);
        `CHK("event", 1'b1, portMatchEvent)
        if (portMatchEvent !== 1'b1) stop_test();
    endtask

    // Masked match on both ports
    task automatic match;
        portMatchIrqEnable = 1'b1;
        wr(8'hd7, 8'h03);
        wr(8'hc7, 8'h0f);
        extVal = 16'ha543;
        tick(4);
        `CHK("masked", 1'b0, portMatchEvent)
        extVal = 16'ha541;
        waitEvent();
        `CHK("irq", 1'b1, portMatchIrq)
        `CHK("wake", 1'b1, oscWakeReq)
        portMatchIrqEnable = 1'b0;
        tick(2);
        `CHK("irq off", 1'b0, portMatchIrq)
        wr(8'hc7, 8'h00);
        wr(8'hbf, 8'h01);
        wr(8'hcf, 8'h00);
        waitEvent();
        wr(8'hbf, 8'h00);
        tick(4);
        `CHK("idle", 1'b0, portMatchEvent)
    endtask

    // Input routing takes the lowest unskipped pin
    task automatic routing;
        wr(8'he2, 8'h50);
        tick(4);
        `CHK("t0 pin0", 1'b1, timer0In)
        wr(8'hd4, 8'h01);
        tick(4);
        `CHK("t0 pin1", 1'b0, timer0In)
        wr(8'hd4, 8'h00);
        wr(8'he2, 8'h60);
        tick(4);
        `CHK("t0 off", 1'b0, timer0In)
        `CHK("t1", 1'b1, timer1In)
        wr(8'he2, 8'h48);
        tick(4);
        `CHK("count", 1'b1, counterCountIn)
    endtask

    // Output drivers, pullups, two-wire and compare outputs
    task automatic drive;
        extEn = 16'h0000;
        wr(8'he2, 8'h00);
        wr(8'h80, 8'h5a);
        wr(8'ha4, 8'h0f);
        tick(3);
        `CHK("xbar off", 16'hffff, pinOeN)
        wr(8'he2, 8'h40);
        tick(3);
        `CHK("oe", 16'hff50, pinOeN)
        `CHK("out", 8'h5a, pinOut[7:0])
        `CHK("pullups", 16'hff50, pinPullupEn)
        wr(8'h80, 8'hff);
        wr(8'ha4, 8'hff);
        smbRouteEn = 1'b1; smbDataOut = 1'b1; smbClkOut = 1'b0;
        wr(8'he2, 8'h46);
        tick(3);
        `CHK("two-wire oe", 2'b01, pinOeN[1:0])
        `CHK("cex", 6'h00, pinOut[7:2])
        wr(8'he2, 8'h47);
        tick(3);
        `CHK("reserved", 6'h3f, pinOut[7:2])
        `CHK("scl in", 1'b0, smbClkIn)
        wr(8'he2, 8'hc0);
        tick(3);
        `CHK("no pullups", 16'h0000, pinPullupEn)
    endtask

    // Main sequence
    initial begin
        {sfrWrEn, sfrRdEn, sfrRmw, bitWrEn, bitWrData, bitRdEn, bitRmw} = '0;
        {sfrAddr, sfrWrData, bitAddr, extEn, extVal, cexOut} = '0;
        {smbRouteEn, smbDataOut, smbClkOut, portMatchIrqEnable} = '0;
        errorCnt = 0; testsRun = 0; rst = 1'b1;
        tick(8);
        rst = 1'b0;
        tick(3);
        resetState();
        latchAccess();
        pinRead();
        match();
        routing();
        drive();
        stop_test();
    end
endmodule
